// File: irma_defines.vh
/*
 defines for the interrupt request / mask / accept block: register offsets,
 field positions, reset values, acceptance constants.
 assumes inclusion by bare name from the design files.
*/
`ifndef IRMA_DEFINES_VH
`define IRMA_DEFINES_VH

`define IRMA_OFF_REQ        8'h00
`define IRMA_OFF_MASK       8'h04
`define IRMA_OFF_MASK_CLR   8'h08
`define IRMA_OFF_PRIO       8'h0C
`define IRMA_OFF_EVENT      8'h10
`define IRMA_OFF_STATUS     8'h14
`define IRMA_OFF_SAVED_SR   8'h18
`define IRMA_OFF_SAVED_PC   8'h1C
`define IRMA_OFF_SAVED_SP   8'h20
`define IRMA_OFF_VBR        8'h24
`define IRMA_OFF_ACK        8'h28

`define IRMA_MASK_RESET     32'h000003FF
`define IRMA_MASK_IMPL      32'h000003FF
`define IRMA_SRC_MASK       32'h00000300
`define IRMA_BIT_TMR3       8
`define IRMA_BIT_TMR4       9

`define IRMA_PRIO_TMR3_LO   8
`define IRMA_PRIO_TMR4_LO   12
`define IRMA_PRIO_IMPL      32'h0000FF00

`define IRMA_SR_BL          28
`define IRMA_SR_MD          30
`define IRMA_SR_RB          29
`define IRMA_SR_CPU_MASK_LEVEL_LO    4
`define IRMA_SR_RESET       32'h700000F0

`define IRMA_VEC_OFFSET     32'h00000600
`define IRMA_EVT_TMR3       12'h580
`define IRMA_EVT_TMR4       12'hB80

`endif

// File: irma_arbiter.v
/*
 priority arbiter for the two timer underflow sources.
 assumes requests already gated by the individual mask; combinational.
*/
`timescale 1ns/1ps
`include "irma_defines.vh"

module irma_arbiter (
   input  wire [1:0] req,
   input  wire [7:0] prio,
   output reg        valid,
   output reg        sel,
   output reg  [3:0] level
);
   wire [3:0] lvl3;
   wire [3:0] lvl4;
   assign lvl3 = prio[3:0];
   assign lvl4 = prio[7:4];

   always @* begin
      valid = 1'b0;
      sel   = 1'b0;
      level = 4'h0;
      // level 0 never wins, so a zero field masks its source  [R21]
      if (req[0] && lvl3 != 4'h0) begin
         valid = 1'b1;
         sel   = 1'b0;
         level = lvl3;
      end
      // strictly greater wins; a tie keeps channel 3 by fixed order  [R8] [R9]
      if (req[1] && lvl4 != 4'h0 && (!valid || lvl4 > level)) begin
         valid = 1'b1;
         sel   = 1'b1;
         level = lvl4;
      end
   end
endmodule

// File: irma_top.v
/*
 interrupt request / mask / acceptance logic for the timer underflow
 sources, with a tiny model of the status word and saved registers.
 the request register mirrors the source lines, the mask register is set
 by ones written to it and cleared by ones written to the mask-clear
 register, and a two-source arbiter picks the level forwarded to the core.
 assumes a single-cycle register port and a core that raises
 insn_boundary between instructions and presents pc and sp there.
 assumes the source lines are synchronous to ref_clk and that software
 never strobes a write and a read in the same cycle.
*/
// How it works
// R1: request register shows pending regardless of masks
// R2: request bit reads one while pending
// R3: mask resets to 0x3FF, kept in standby
// R4: writing zero to mask changes nothing
// R5: mask one blocks, zero passes source
// R6: mask-clear ones unmask, zeros leave alone
// R7: bit 9 timer four, bit 8 three
// R8: highest programmed level wins, others wait
// R9: ties resolved by fixed source order
// R10: forward only if level above mask level
// R11: accept only at instruction boundary
// R12: acceptance loads event code register
// R13: acceptance saves status, pc, stack pointer
// R14: acceptance sets block, privilege, bank flags
// R15: fetch starts at vector base plus 0x600
// R16: acceptance leaves mask level unchanged
// R17: handler clears source, waits before unblocking
// R18: software unmasks through the mask-clear register
// R19: nesting handler saves, unblocks, raises level
// R20: cleared block flag admits higher levels
// R21: four-bit level, zero masks source
// R22: request writes ignored, reserved reads zero
`timescale 1ns/1ps
`include "irma_defines.vh"

module irma_top (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   input  wire        tmr3_underflow,
   input  wire        tmr4_underflow,
   input  wire        standby,
   input  wire        insn_boundary,
   input  wire [31:0] cpu_pc,
   input  wire [31:0] cpu_sp,
   output reg         cpu_irq,
   output reg         accept_pulse,
   output reg  [31:0] fetch_addr,
   output reg  [31:0] status_word_q
);
   reg  [31:0] source_request_status_q;
   reg  [31:0] source_mask_q;
   reg  [31:0] timer_priority_fields_q;
   reg  [11:0] event_code_q;
   reg  [31:0] saved_status_q;
   reg  [31:0] saved_pc_q;
   reg  [31:0] saved_sp_q;
   reg  [31:0] vector_base_q;
   reg  [31:0] status_d;
   reg  [31:0] rd_view;
   reg  [1:0]  seq_q;
   reg  [1:0]  seq_d;

   wire [1:0]  gated_req;
   wire        arb_valid;
   wire        arb_sel;
   wire [3:0]  arb_level;
   wire [3:0]  cpu_mask_level;
   wire        block_flag;
   wire        take;
   wire        wr_req;
   wire        wr_mask;
   wire        wr_mask_clr;
   wire        wr_prio;
   wire        wr_status;
   wire        wr_saved_sr;
   wire        wr_saved_pc;
   wire        wr_vbr;
   wire        level_above;
   wire [1:0]  src_level;
   wire [31:0] req_d;
   wire [31:0] mask_d;

   localparam [31:0] MASK_IMPL = `IRMA_MASK_IMPL;
   localparam [31:0] SRC_BITS  = `IRMA_SRC_MASK;
   localparam [1:0]  ST_WAIT   = 2'b01;
   localparam [1:0]  ST_DONE   = 2'b10;

   genvar gi;

   function sel_wr;
      input [7:0] a;
      input [7:0] off;
      input       we;
      begin
         sel_wr = we && (a == off);
      end
   endfunction

   // write-one-sets / write-one-clears update of one mask bit  [R4] [R6]
   function mask_next;
      input q;
      input w;
      input set;
      input clr;
      begin
         if (set) begin
            mask_next = q | w;
         end else if (clr) begin
            mask_next = q & ~w;
         end else begin
            mask_next = q;
         end
      end
   endfunction

   function [11:0] event_of;
      input s;
      begin
         event_of = s ? `IRMA_EVT_TMR4 : `IRMA_EVT_TMR3;
      end
   endfunction

   assign wr_req      = sel_wr(reg_addr, `IRMA_OFF_REQ, reg_wr);
   assign wr_mask     = sel_wr(reg_addr, `IRMA_OFF_MASK, reg_wr);
   assign wr_mask_clr = sel_wr(reg_addr, `IRMA_OFF_MASK_CLR, reg_wr);
   assign wr_prio     = sel_wr(reg_addr, `IRMA_OFF_PRIO, reg_wr);
   assign wr_status   = sel_wr(reg_addr, `IRMA_OFF_STATUS, reg_wr);
   assign wr_saved_sr = sel_wr(reg_addr, `IRMA_OFF_SAVED_SR, reg_wr);
   assign wr_saved_pc = sel_wr(reg_addr, `IRMA_OFF_SAVED_PC, reg_wr);
   assign wr_vbr      = sel_wr(reg_addr, `IRMA_OFF_VBR, reg_wr);

   // mask bit set blocks its source from arbitration  [R5] [R7]
   assign gated_req = source_request_status_q[`IRMA_BIT_TMR4:`IRMA_BIT_TMR3]
                    & ~source_mask_q[`IRMA_BIT_TMR4:`IRMA_BIT_TMR3];

   irma_arbiter u_arb (
      .req   (gated_req),
      .prio  (timer_priority_fields_q[15:8]),
      .valid (arb_valid),
      .sel   (arb_sel),
      .level (arb_level)
   );

   assign cpu_mask_level = status_word_q[`IRMA_SR_CPU_MASK_LEVEL_LO+3:`IRMA_SR_CPU_MASK_LEVEL_LO];
   assign block_flag     = status_word_q[`IRMA_SR_BL];
   assign level_above    = arb_valid && (arb_level > cpu_mask_level);
   // a cleared block flag with raised mask level still admits higher ones;
   // the live level check stops a request that a fresh mask level outranks
   // [R10] [R11] [R20]
   assign take = cpu_irq && level_above && !block_flag && insn_boundary;

   // request register follows the sources directly; it is a level, not a
   // latch, so a source deasserting its line clears the bit  [R1] [R2]
   // software writes to it go nowhere  [R22]
   assign src_level = {tmr4_underflow, tmr3_underflow}; // [R7]

   // per-bit next values; reserved bits are tied low  [R7] [R22]
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_bit
         if (SRC_BITS[gi]) begin : g_src
            assign req_d[gi] = src_level[gi-`IRMA_BIT_TMR3];
         end else begin : g_nosrc
            assign req_d[gi] = 1'b0;
         end
         if (MASK_IMPL[gi]) begin : g_msk
            // only ones take effect on the mask  [R4] [R6]
            assign mask_d[gi] = mask_next(source_mask_q[gi], reg_wdata[gi],
                                          wr_mask, wr_mask_clr);
         end else begin : g_nomsk
            assign mask_d[gi] = 1'b0;
         end
      end
   endgenerate

   always @(posedge ref_clk) begin
      if (rst) begin
         source_request_status_q <= 32'h00000000;
      end else begin
         source_request_status_q <= req_d; // [R1] [R2]
      end
   end

   // standby is not a reset, so the mask simply holds  [R3]
   always @(posedge ref_clk) begin
      if (rst) begin
         source_mask_q <= `IRMA_MASK_RESET; // [R3]
      end else begin
         source_mask_q <= mask_d; // [R5]
      end
   end

   // levels live in the two timer nibbles; the rest read 0  [R21]
   always @(posedge ref_clk) begin
      if (rst) begin
         timer_priority_fields_q <= 32'h00000000;
      end else if (wr_prio) begin
         timer_priority_fields_q <= reg_wdata & `IRMA_PRIO_IMPL; // [R21]
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         vector_base_q <= 32'h00000000;
      end else if (wr_vbr) begin
         vector_base_q <= reg_wdata;
      end
   end

   // forward only a strictly higher level than the cpu mask  [R10]
   always @(posedge ref_clk) begin
      if (rst) begin
         cpu_irq <= 1'b0;
      end else begin
         cpu_irq <= level_above && !take;
      end
   end

   always @* begin
      status_d = status_word_q;
      if (wr_status) begin
         status_d = reg_wdata;
      end
      if (take) begin
         // mask level bits untouched by acceptance  [R16]
         status_d[`IRMA_SR_BL] = 1'b1; // [R14]
         status_d[`IRMA_SR_MD] = 1'b1; // [R14]
         status_d[`IRMA_SR_RB] = 1'b1; // [R14]
      end
   end

   // acceptance's BL, MD and RB bits win over a same-cycle software write to the status word
   always @(posedge ref_clk) begin
      if (rst) begin
         status_word_q <= `IRMA_SR_RESET;
      end else begin
         status_word_q <= status_d;
      end
   end

   // acceptance marker: done lasts one cycle, as BL blocks a second take
   always @* begin
      case (seq_q)
         ST_WAIT: begin
            seq_d = take ? ST_DONE : ST_WAIT;
         end
         ST_DONE: begin
            seq_d = take ? ST_DONE : ST_WAIT;
         end
         default: begin
            seq_d = ST_WAIT;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         seq_q        <= ST_WAIT;
         accept_pulse <= 1'b0;
      end else begin
         seq_q        <= seq_d;
         accept_pulse <= (seq_d == ST_DONE);
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         event_code_q <= 12'h000;
      end else if (take) begin
         event_code_q <= event_of(arb_sel); // [R12]
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         saved_status_q <= 32'h00000000;
      end else if (take) begin
         saved_status_q <= status_word_q; // [R13]
      end else if (wr_saved_sr) begin
         saved_status_q <= reg_wdata;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         saved_pc_q <= 32'h00000000;
      end else if (take) begin
         saved_pc_q <= cpu_pc; // [R13]
      end else if (wr_saved_pc) begin
         saved_pc_q <= reg_wdata;
      end
   end

   // saved stack pointer is only loaded by acceptance
   always @(posedge ref_clk) begin
      if (rst) begin
         saved_sp_q <= 32'h00000000;
      end else if (take) begin
         saved_sp_q <= cpu_sp; // [R13]
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         fetch_addr <= 32'h00000000;
      end else if (take) begin
         fetch_addr <= vector_base_q + `IRMA_VEC_OFFSET; // [R15]
      end
   end

   // read view of the addressed register; unmapped and write-only give 0
   always @* begin
      rd_view = 32'h00000000;
      case (reg_addr)
         `IRMA_OFF_REQ:      rd_view = source_request_status_q; // [R1]
         `IRMA_OFF_MASK:     rd_view = source_mask_q; // [R22]
         `IRMA_OFF_PRIO:     rd_view = timer_priority_fields_q;
         `IRMA_OFF_EVENT:    rd_view = {20'h00000, event_code_q};
         `IRMA_OFF_STATUS:   rd_view = status_word_q;
         `IRMA_OFF_SAVED_SR: rd_view = saved_status_q;
         `IRMA_OFF_SAVED_PC: rd_view = saved_pc_q;
         `IRMA_OFF_SAVED_SP: rd_view = saved_sp_q;
         `IRMA_OFF_VBR:      rd_view = vector_base_q;
         default:            rd_view = 32'h00000000; // [R22]
      endcase
   end

   // read data one cycle after the strobe, 0 in every other cycle
   always @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= rd_view;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule

// File: irma_chk.sv
/* port checker for irma_top, bound at the foot.
   assumes status flags at 30:28 (block 28) and level at 7:4. */
`timescale 1ns/1ps
module irma_chk (
   input wire        ref_clk,
   input wire        rst,
   input wire [7:0]  reg_addr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   input wire        tmr3_underflow,
   input wire        tmr4_underflow,
   input wire        insn_boundary,
   input wire        cpu_irq,
   input wire        accept_pulse,
   input wire [31:0] status_word_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_take_point: assert property (
      accept_pulse |-> $past(cpu_irq & insn_boundary & ~status_word_q[28]))
      else $error("take without cause");
   a_flags_set: assert property (
      accept_pulse |-> status_word_q[30:28] == 3'h7) else $error("flags");
   a_level_kept: assert property (
      accept_pulse |-> status_word_q[7:4] == $past(status_word_q[7:4]))
      else $error("level moved");
   a_single_take: assert property (
      accept_pulse |-> !cpu_irq ##1 !accept_pulse) else $error("retake");
   a_irq_cause: assert property (
      cpu_irq |-> $past(tmr3_underflow | tmr4_underflow, 2))
      else $error("irq without source");
   a_req_view: assert property (
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == {22'h0,
      $past(tmr4_underflow, 2), $past(tmr3_underflow, 2), 8'h00})
      else $error("request view");
   a_mask_rsvd: assert property (
      reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:10] == 22'h0)
      else $error("mask reserved");
   a_clr_silent: assert property (
      reg_rd && reg_addr == 8'h08 |=> reg_rdata == 32'h0) else $error("wo");
   a_idle_zero: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("idle data");
   c_take: cover property (accept_pulse);
   c_held: cover property (cpu_irq && status_word_q[28]);
   c_both: cover property (tmr3_underflow && tmr4_underflow && reg_rd);
endmodule
bind irma_top irma_chk u_irma_chk (.ref_clk(ref_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .tmr3_underflow(tmr3_underflow), .tmr4_underflow(tmr4_underflow),
   .insn_boundary(insn_boundary), .cpu_irq(cpu_irq),
   .accept_pulse(accept_pulse), .status_word_q(status_word_q));

// File: irma_core_model.sv
/* core and timer model on the far side of irma_top.
   assumes the bench sets source levels and the pace. */
`timescale 1ns/1ps
module irma_core_model #(
   parameter [31:0] PC0 = 32'h00004000,
   parameter [31:0] SP0 = 32'h0000FF00
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [1:0]  src,
   input  wire        slow,
   output reg         tmr3_underflow,
   output reg         tmr4_underflow,
   output reg         insn_boundary,
   output wire [31:0] cpu_pc,
   output wire [31:0] cpu_sp
);
   // fixed pc/sp keeps saved values predictable
   assign cpu_pc = PC0;
   assign cpu_sp = SP0;
   always @(posedge ref_clk) begin
      // slow pace: boundary only every other cycle
      insn_boundary <= rst ? 1'b0 : (slow ? ~insn_boundary : 1'b1);
      // a source holds until the bench clears src
      {tmr4_underflow, tmr3_underflow} <= rst ? 2'b00 : src;
   end
endmodule

// File: tb.sv
/* self-checking bench for irma_top with a queue-free int model.
   assumes irma_core_model on the far side and irma_chk bound. */
`timescale 1ns/1ps
module tb;
   reg         ref_clk, rst, reg_wr, reg_rd, standby, slow;
   reg  [7:0]  reg_addr;
   reg  [31:0] reg_wdata, vector_base_reg, rv;
   reg  [1:0]  src;
   wire [31:0] reg_rdata, fetch_addr, status_word_q, pc, sp;
   wire        t3, t4, ib, cpu_irq, accept_pulse;
   int         failures = 0, tests_run = 0, msk = 'h3FF, i, s;
   irma_top u_irma_top (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tmr3_underflow(t3), .tmr4_underflow(t4),
      .standby(standby), .insn_boundary(ib), .cpu_pc(pc), .cpu_sp(sp),
      .cpu_irq(cpu_irq), .accept_pulse(accept_pulse),
      .fetch_addr(fetch_addr), .status_word_q(status_word_q));
   irma_core_model u_irma_core_model (.ref_clk(ref_clk), .rst(rst),
      .src(src), .slow(slow), .tmr3_underflow(t3), .tmr4_underflow(t4),
      .insn_boundary(ib), .cpu_pc(pc), .cpu_sp(sp));
   initial begin
      ref_clk = 0;
      forever #2 ref_clk = ~ref_clk;
   end
   task tally_and_finish;
      begin
         $display("checks %0d failures %0d", tests_run, failures);
         if (failures == 0 && tests_run > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task cmp(input [31:0] g, input [31:0] e);
      begin
         tests_run++;
         if (g !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rdc(input [7:0] a, input [31:0] e);
      begin
         reg_addr <= a; reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1 rv = reg_rdata;
         cmp(rv, e);
      end
   endtask
   // ties go to channel 3: strict compare against its level
   function int ev(int s, int p3, int p4, int im);
      int l;
      begin
         l = (s[0] && !msk[8] && p3 > im) ? p3 : 0;
         if (s[1] && !msk[9] && p4 > im && p4 > l) return 'hB80;
         return l ? 'h580 : 0;
      end
   endfunction
   task run(input int s, input int p3, input int p4, input int sr);
      int e, got;
      begin
         e = ev(s, p3, p4, sr >> 4);
         got = 0;
         wr(8'h0C, (p4 << 12) | (p3 << 8));
         src <= s[1:0];
         slow <= $urandom;
         repeat (3) @(posedge ref_clk);
         wr(8'h14, sr); // sources settle before unblocking
         repeat (8) begin
            @(posedge ref_clk);
            #1 if (accept_pulse === 1'b1) got = 1;
         end
         src <= 2'b00;
         cmp(got, e != 0);
         if (got) begin
            rdc(8'h10, e);
            rdc(8'h18, sr);
            rdc(8'h1C, pc);
            rdc(8'h20, sp);
            cmp(status_word_q, sr | 32'h70000000);
            cmp(fetch_addr, vector_base_reg + 32'h600);
         end
         wr(8'h14, 32'h70000000); // block again before return
         repeat (3) @(posedge ref_clk);
      end
   endtask
   initial begin
      rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
      standby = 0; slow = 0; src = 0;
      i = $urandom(38447);
      repeat (8) @(posedge ref_clk);
      rst <= 0;
      @(posedge ref_clk);
      cmp(status_word_q, 32'h700000F0);
      wr(8'h04, 32'h0);
      rdc(8'h04, 32'h3FF);
      src <= 2'b10;
      wr(8'h00, 32'hFFFFFFFF);
      repeat (2) @(posedge ref_clk);
      rdc(8'h00, 32'h200);
      src <= 2'b00;
      for (i = 0; i < 6; i++) begin
         s = $urandom;
         standby <= s[0];
         if (s[1]) begin
            wr(8'h04, s); msk |= s & 'h3FF;
         end else begin
            wr(8'h08, s); msk &= ~s;
         end
         rdc(8'h04, msk);
      end
      vector_base_reg = $urandom;
      wr(8'h24, vector_base_reg);
      wr(8'h08, 32'h300); msk &= ~'h300;
      run(1, 5, 9, 'h00);
      run(3, 5, 9, 'h50);
      run(3, 7, 7, 'h00);
      run(3, 7, 7, 'h70);
      run(1, 0, 9, 'h00);
      run(2, 9, 15, 'hE0);
      wr(8'h04, 32'h100); msk |= 'h100;
      run(1, 5, 5, 'h00);
      for (i = 0; i < 6; i++)
         run($urandom % 4, $urandom % 16, $urandom % 16, ($urandom % 16) << 4);
      tally_and_finish;
   end
   initial begin
      #20000;
      failures++;
      tally_and_finish;
   end
endmodule
